// ==== common/pmevt_pkg.sv ====
// Purpose: Shared constants and types of the event packet block
// Assumes: 100 MHz aclk, AXI4-Lite register access, 28-bit byte addresses
// Notes: Offsets are byte addresses
package pmevt_pkg;

	localparam int ADDR_W = 28;
	localparam int DATA_W = 32;

	// Register byte addresses
	localparam logic [ADDR_W-1:0] OFF_PACKET = 28'h000850C;
	localparam logic [ADDR_W-1:0] OFF_WBASE  = 28'hFFFFF6C;
	localparam logic [ADDR_W-1:0] OFF_WMASK  = 28'hFFFFF7C;
	localparam logic [ADDR_W-1:0] OFF_EVT_EN = 28'h0008510;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 28'h0008514;

	// Field positions
	localparam int WIN_LO   = 2;
	localparam int WIN_HI   = 27;
	localparam int MASK_WE  = 1;
	localparam int MASK_RE  = 0;
	localparam int EN_FETCH = 6;
	localparam int EN_GFX   = 0;
	localparam int ST_BUSY  = 0;
	localparam int ST_EXPD  = 1;
	localparam int PKT_W    = 8;
	localparam int BYTE_W   = 8;

	// Writable bits and reset values
	localparam logic [DATA_W-1:0] WBASE_WR_MASK  = 32'h0FFFFFFC;
	localparam logic [DATA_W-1:0] WMASK_WR_MASK  = 32'h0FFFFFFF;
	localparam logic [DATA_W-1:0] EVT_EN_WR_MASK = 32'h00000041;
	localparam logic [DATA_W-1:0] RST_WBASE      = 32'h00000000;
	localparam logic [DATA_W-1:0] RST_WMASK      = 32'h00000000;
	localparam logic [DATA_W-1:0] RST_EVT_EN     = 32'h00000000;
	localparam logic [PKT_W-1:0]  RST_PACKET     = 8'h00;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SER_BIT_NS      = 80;
	localparam int SER_BIT_CYCLES  = (SER_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INTERVAL_US     = 100;
	localparam int INTERVAL_CYC_DF = (INTERVAL_US * 1000) / CLK_PERIOD_NS;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [ADDR_W-1:0] addr;
	} pmevt_cyc_t;

	typedef struct packed {
		logic       vsync;
		logic       fetch;
		logic [3:0] rsvd;
		logic       win;
		logic       gfx;
	} pmevt_pkt_t;

	typedef enum {
		PMEVT_IDLE,
		PMEVT_SHIFT,
		PMEVT_DONE
	} pmevt_tx_state_t;

endpackage

// ==== logic/pmevt_top.sv ====
// Purpose: Event capture into the serial packet register and serial send
// Assumes: Event inputs come from logic on aclk; single clock domain
// Notes: AXI4-Lite slave, one write and one read in flight
//
// Operation
// R1 - Vertical sync event sets packet bit 7 one cycle later.
// R2 - Enabled instruction fetch event sets packet bit 6.
// R3 - Address window hit sets packet bit 1.
// R4 - Enabled graphics region access sets packet bit 0.
// R5 - Bits 31:8 unused, bits 5:2 reserved and read zero.
// R6 - Packet register read-only; low byte resets to zero.
// R7 - Send only when a bit is set and interval elapsed.
// R8 - A set bit stays until its packet is sent, then clears.
// R9 - Repeat events of an already set type are ignored.
// R10 - Distinct events accumulate and go out in one packet.
// R11 - Companion decodes each received packet.
// R12 - Window base field is bits 27:2, word aligned.
// R13 - Clear mask bit requires match; set mask bit always matches.
// R14 - Hit needs enabled cycle type and all unmasked bits matching.
// R15 - Mask bit 1 enables write cycle comparison.
// R16 - Mask bit 0 enables read cycle comparison.
// R17 - Base reserved bits read zero; window registers reset zero.
// R18 - Window may sit anywhere in 256 MB space.
// R19 - Interval period and serial bit order are parameters.
`timescale 1ns/10ps
`default_nettype none

module pmevt_top #(
	parameter int unsigned INTERVAL_CYCLES = pmevt_pkg::INTERVAL_CYC_DF,
	parameter bit          LSB_FIRST       = 1'b0
) (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic                           ce,
	input  wire logic [pmevt_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output logic                                s_axi_awready,
	input  wire logic [pmevt_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output logic                                s_axi_wready,
	output logic [1:0]                          s_axi_bresp,
	output logic                                s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [pmevt_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output logic                                s_axi_arready,
	output logic [pmevt_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                          s_axi_rresp,
	output logic                                s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic                           vertical_interrupt_flag,
	input  wire logic                           instruction_fetch_event,
	input  wire logic                           graphics_access_event,
	input  wire pmevt_pkg::pmevt_cyc_t          cpu_cycle,
	output logic                                ser_frame,
	output logic                                ser_data,
	output logic                                ser_done
);
	import pmevt_pkg::*;

	localparam logic [31:0] IVL_LOAD = 32'(INTERVAL_CYCLES - 1);
	localparam logic [7:0]  BIT_LAST = 8'(SER_BIT_CYCLES - 1);
	localparam logic [2:0]  CNT_LAST = 3'(PKT_W - 1);
	localparam logic [3:0]  RSVD_Z   = 4'h0;

	logic [DATA_W-1:0]  wbase_reg;
	logic [DATA_W-1:0]  wmask_reg;
	logic [DATA_W-1:0]  evt_en_reg;
	pmevt_pkt_t         packet_reg;
	pmevt_pkt_t         packet_next;
	pmevt_pkt_t         set_vec;
	logic [PKT_W-1:0]   snap_reg;
	logic [PKT_W-1:0]   clr_vec;
	logic [31:0]        ivl_cnt_reg;
	logic               expired;
	pmevt_tx_state_t    tx_state_reg;
	logic [2:0]         bit_cnt_reg;
	logic [7:0]         bit_tmr_reg;
	logic               win_hit;
	logic               type_ok;
	logic [WIN_HI:WIN_LO] addr_diff;
	logic [2:0]         tx_idx;
	logic               start_tx;
	logic [DATA_W-1:0]  status_word;

	logic               aw_held_reg;
	logic               w_held_reg;
	logic [ADDR_W-1:0]  aw_addr_reg;
	logic [DATA_W-1:0]  w_data_reg;
	logic [3:0]         w_strb_reg;
	logic               bvalid_reg;
	logic [1:0]         bresp_reg;
	logic               rvalid_reg;
	logic [1:0]         rresp_reg;
	logic [DATA_W-1:0]  rdata_reg;
	logic               wr_go;
	logic               aw_hs;
	logic               w_hs;
	logic               ar_hs;
	logic               ser_frame_reg;
	logic               ser_data_reg;
	logic               ser_done_reg;
	logic               wr_is_wbase;
	logic               wr_is_wmask;
	logic               wr_is_evt_en;
	logic               wr_mapped;

	function automatic logic [DATA_W-1:0] merge_bytes(
		input logic [DATA_W-1:0] old_v,
		input logic [DATA_W-1:0] new_v,
		input logic [3:0]        strb,
		input logic [DATA_W-1:0] wr_mask
	);
		logic [DATA_W-1:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*BYTE_W +: BYTE_W] = new_v[i*BYTE_W +: BYTE_W];
			end
		end
		return res & wr_mask;
	endfunction

	// Window comparator
	always_comb begin
		addr_diff = (cpu_cycle.addr[WIN_HI:WIN_LO] ^ wbase_reg[WIN_HI:WIN_LO])
			& ~wmask_reg[WIN_HI:WIN_LO]; // R12 R13 R18
		type_ok = (cpu_cycle.write & wmask_reg[MASK_WE]) // R15
			| (~cpu_cycle.write & wmask_reg[MASK_RE]); // R16
		win_hit = cpu_cycle.valid & type_ok & (addr_diff == '0); // R14
	end

	// Event set vector and completion clear
	always_comb begin
		set_vec       = '0;
		set_vec.vsync = vertical_interrupt_flag; // R1
		set_vec.fetch = instruction_fetch_event & evt_en_reg[EN_FETCH]; // R2
		set_vec.win   = win_hit; // R3
		set_vec.gfx   = graphics_access_event & evt_en_reg[EN_GFX]; // R4
		clr_vec       = (tx_state_reg == PMEVT_DONE) ? snap_reg : '0; // R8
	end

	// New events win over the completion clear
	always_comb begin
		packet_next      = pmevt_pkt_t'((packet_reg & ~clr_vec) | set_vec); // R9 R10
		packet_next.rsvd = RSVD_Z; // R5
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			packet_reg <= RST_PACKET; // R6
		end else if (ce) begin
			packet_reg <= packet_next; // R8 R9 R10
		end
	end

	// Interval counter, restarted by each completed packet
	assign expired = (ivl_cnt_reg == '0);
	// Start needs a pending bit and an elapsed interval
	assign start_tx = expired && (packet_reg != '0); // R7

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ivl_cnt_reg <= IVL_LOAD;
		end else if (ce) begin
			if (tx_state_reg == PMEVT_DONE) begin
				ivl_cnt_reg <= IVL_LOAD; // R19
			end else if (!expired) begin
				ivl_cnt_reg <= ivl_cnt_reg - 32'h00000001;
			end
		end
	end

	// Serial transmitter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_state_reg <= PMEVT_IDLE;
			snap_reg     <= '0;
			bit_cnt_reg  <= '0;
			bit_tmr_reg  <= '0;
		end else if (ce) begin
			case (tx_state_reg)
				PMEVT_IDLE: begin
					if (start_tx) begin // R7
						snap_reg     <= packet_reg;
						bit_cnt_reg  <= '0;
						bit_tmr_reg  <= '0;
						tx_state_reg <= PMEVT_SHIFT;
					end
				end
				PMEVT_SHIFT: begin
					if (bit_tmr_reg == BIT_LAST) begin
						bit_tmr_reg <= '0;
						if (bit_cnt_reg == CNT_LAST) begin
							tx_state_reg <= PMEVT_DONE;
						end else begin
							bit_cnt_reg <= bit_cnt_reg + 3'h1;
						end
					end else begin
						bit_tmr_reg <= bit_tmr_reg + 8'h01;
					end
				end
				PMEVT_DONE: begin
					tx_state_reg <= PMEVT_IDLE;
				end
				default: begin
					tx_state_reg <= PMEVT_IDLE;
				end
			endcase
		end
	end

	// Bit order fixed at build time
	always_comb begin
		if (LSB_FIRST) begin
			tx_idx = bit_cnt_reg; // R19
		end else begin
			tx_idx = CNT_LAST - bit_cnt_reg; // R19
		end
	end

	// Registered line outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ser_frame_reg <= 1'b0;
			ser_data_reg  <= 1'b0;
			ser_done_reg  <= 1'b0;
		end else if (ce) begin
			ser_done_reg  <= (tx_state_reg == PMEVT_DONE);
			ser_frame_reg <= (tx_state_reg == PMEVT_SHIFT);
			if (tx_state_reg == PMEVT_SHIFT) begin
				ser_data_reg <= snap_reg[tx_idx]; // R19
			end else begin
				ser_data_reg <= 1'b0;
			end
		end
	end

	assign ser_frame = ser_frame_reg;
	assign ser_data  = ser_data_reg;
	assign ser_done  = ser_done_reg;

	// AXI4-Lite handshakes, stalled while ce is low
	assign s_axi_awready = ce & ~aw_held_reg & ~bvalid_reg;
	assign s_axi_wready  = ce & ~w_held_reg & ~bvalid_reg;
	assign s_axi_arready = ce & ~rvalid_reg;
	assign aw_hs         = s_axi_awvalid & s_axi_awready;
	assign w_hs          = s_axi_wvalid & s_axi_wready;
	assign ar_hs         = s_axi_arvalid & s_axi_arready;
	assign wr_go         = aw_held_reg & w_held_reg & ~bvalid_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= '0;
		end else if (ce) begin
			if (aw_hs) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_go) begin
				aw_held_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_reg <= 1'b0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
		end else if (ce) begin
			if (w_hs) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_go) begin
				w_held_reg <= 1'b0;
			end
		end
	end

	// Write address decode, used by the response; the update decodes aw_addr_reg itself
	always_comb begin
		wr_is_wbase  = (aw_addr_reg == OFF_WBASE);
		wr_is_wmask  = (aw_addr_reg == OFF_WMASK);
		wr_is_evt_en = (aw_addr_reg == OFF_EVT_EN);
		wr_mapped    = wr_is_wbase | wr_is_wmask | wr_is_evt_en;
	end

	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wbase_reg  <= RST_WBASE; // R17
			wmask_reg  <= RST_WMASK; // R17
			evt_en_reg <= RST_EVT_EN;
		end else if (ce && wr_go) begin
			case (aw_addr_reg)
				OFF_WBASE: begin
					wbase_reg <= merge_bytes(wbase_reg, w_data_reg, w_strb_reg,
						WBASE_WR_MASK); // R12 R17
				end
				OFF_WMASK: begin
					wmask_reg <= merge_bytes(wmask_reg, w_data_reg, w_strb_reg,
						WMASK_WR_MASK);
				end
				OFF_EVT_EN: begin
					evt_en_reg <= merge_bytes(evt_en_reg, w_data_reg, w_strb_reg,
						EVT_EN_WR_MASK);
				end
				default: begin
				end
			endcase
		end
	end

	// Write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= RESP_OKAY;
		end else if (ce) begin
			if (wr_go) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR; // R6
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// Status word: busy from snapshot to completion
	always_comb begin
		status_word          = '0;
		status_word[ST_BUSY] = (tx_state_reg != PMEVT_IDLE);
		status_word[ST_EXPD] = expired;
	end

	// Read path
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= RESP_OKAY;
			rdata_reg  <= '0;
		end else if (ce) begin
			if (ar_hs) begin
				rvalid_reg <= 1'b1;
				rresp_reg  <= RESP_OKAY;
				rdata_reg  <= '0;
				case (s_axi_araddr)
					OFF_PACKET: rdata_reg <= {24'h000000, packet_reg}; // R5 R6
					OFF_WBASE:  rdata_reg <= wbase_reg;
					OFF_WMASK:  rdata_reg <= wmask_reg;
					OFF_EVT_EN: rdata_reg <= evt_en_reg;
					OFF_STATUS: rdata_reg <= status_word;
					default: rresp_reg <= RESP_SLVERR;
				endcase
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp  = rresp_reg;
	assign s_axi_rdata  = rdata_reg;

endmodule

`default_nettype wire

// ==== test/pmevt_top_monitor.sv ====
// Purpose: Port checker for pmevt_top
// Assumes: ce low only while bus and link are idle
// Notes: Bound from the testbench top file
`timescale 1ns/10ps
`default_nettype none
module pmevt_top_monitor #(
	parameter int unsigned INTERVAL_CYCLES = 20
) (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        ser_frame,
	input wire logic        ser_data,
	input wire logic        ser_done
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0]  frm_cnt;
	logic [15:0] gap_cnt;
	always_ff @(posedge aclk) begin
		if (!aresetn || !ser_frame) frm_cnt <= 8'h00;
		else frm_cnt <= frm_cnt + 8'h01;
	end
	// Cycles since the last completed packet
	always_ff @(posedge aclk) begin
		if (!aresetn || ser_done) gap_cnt <= 16'h0000;
		else if (gap_cnt != 16'hFFFF) gap_cnt <= gap_cnt + 16'h0001;
	end
	sequence s_frame_end;
		$fell(ser_frame) ##0 ser_done;
	endsequence
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	chk_data_idle: assert property (!ser_frame |-> !ser_data)
		else $error("data outside frame");
	chk_frame_len: assert property ($fell(ser_frame) |-> frm_cnt == 8'h40 && ser_done)
		else $error("frame length wrong");
	chk_done_pulse: assert property (ser_done |-> s_frame_end ##1 !ser_done)
		else $error("done pulse wrong");
	chk_send_gap: assert property ($rose(ser_frame) |-> gap_cnt >= INTERVAL_CYCLES - 1)
		else $error("frame before interval");
	chk_wr_answer: assert property (s_wr_take |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer late");
	chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
endmodule
`default_nettype wire

// ==== test/pmevt_companion.sv ====
// Purpose: Companion chip model decoding serial event packets
// Assumes: Bit 7 first, eight cycles per bit
// Notes: Samples each bit mid-cell
`timescale 1ns/10ps
`default_nettype none
module pmevt_companion (
	input wire logic   aclk,
	input wire logic   ser_frame,
	input wire logic   ser_data,
	input wire logic   ser_done,
	output logic [7:0] rx_pkt,
	output int         rx_cnt
);
	logic [7:0] shf = 8'h00;
	logic [2:0] ph = 3'h0;
	logic [7:0] pkt = 8'h00;
	int         cnt = 0;
	assign rx_pkt = pkt;
	assign rx_cnt = cnt;
	always @(posedge aclk) begin
		ph <= ser_frame ? ph + 3'h1 : 3'h0;
		if (ser_frame && ph == 3'h3) shf <= {shf[6:0], ser_data};
		// Decode after every transmission
		if (ser_done) begin
			pkt <= shf;
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ==== test/pmevt_top_tb.sv ====
// Purpose: Self-checking bench for pmevt_top
// Assumes: Interval shortened to 300 cycles, ce dropped once while idle
// Notes: Companion model receives the packets
`timescale 1ns/10ps
`default_nettype none
module pmevt_top_tb;
	import pmevt_pkg::*;
	localparam int IV = 300;
	logic              aclk, aresetn, ce;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, r;
	logic [3:0]        s_axi_wstrb;
	logic [1:0]        s_axi_bresp, s_axi_rresp;
	logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic              s_axi_rvalid, s_axi_rready, ser_frame, ser_data, ser_done;
	logic              vertical_interrupt_flag, instruction_fetch_event, graphics_access_event;
	pmevt_cyc_t        cpu_cycle;
	logic [7:0]        rx_pkt;
	int                rx_cnt, errors, samples_checked;
	pmevt_top #(.INTERVAL_CYCLES(IV)) u_pmevt_top (
		.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.vertical_interrupt_flag, .instruction_fetch_event, .graphics_access_event,
		.cpu_cycle, .ser_frame, .ser_data, .ser_done
	);
	pmevt_companion u_pmevt_companion (.aclk, .ser_frame, .ser_data, .ser_done, .rx_pkt, .rx_cnt);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [27:0] a, input logic [31:0] v);
		bit pa, pw;
		pa = 1;
		pw = 1;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (pa || pw) begin
			@(posedge aclk);
			if (s_axi_awready) pa = 0;
			if (s_axi_wready) pw = 0;
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = {30'h0, s_axi_bresp};
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [27:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		@(posedge aclk);
	endtask
	task automatic ev(input logic v, input logic f, input logic g, input pmevt_cyc_t c);
		vertical_interrupt_flag <= v;
		instruction_fetch_event <= f;
		graphics_access_event <= g;
		cpu_cycle <= c;
		@(posedge aclk);
	endtask
	task automatic wait_rx(input int n);
		int k;
		k = 0;
		while (rx_cnt < n && k < 2000) begin
			@(posedge aclk);
			k++;
		end
		chk("rx_cnt", n, rx_cnt);
	endtask
	task automatic t_regs;
		rd(OFF_PACKET, 32'h0, RESP_OKAY);
		rd(OFF_WBASE, 32'h0, RESP_OKAY);
		rd(OFF_WMASK, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		s_axi_wstrb <= 4'h1;
		wr(OFF_PACKET, 32'hC3);
		chk("bresp", 32'h2, r);
		rd(OFF_PACKET, 32'h0, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		wr(OFF_WBASE, 32'h0FFFFFFC);
		rd(OFF_WBASE, 32'h0FFFFFFC, RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		wr(OFF_WBASE, 32'h0);
		chk("bresp", 32'h0, r);
		s_axi_wstrb <= 4'hF;
		rd(OFF_WBASE, 32'h0FFF00FC, RESP_OKAY);
		rd(28'h0000100, 32'h0, RESP_SLVERR);
	endtask
	task automatic t_events;
		wr(OFF_EVT_EN, 32'hFFFFFFFF);
		rd(OFF_EVT_EN, 32'h41, RESP_OKAY);
		wr(OFF_WBASE, 32'h0ABCD000);
		wr(OFF_WMASK, 32'h00000FF2);
		ev(1'b1, 1'b0, 1'b0, '0);
		ev(1'b1, 1'b1, 1'b0, '0);
		ev(1'b0, 1'b0, 1'b1, {1'b1, 1'b1, 28'hABCD5A3});
		ev(1'b0, 1'b0, 1'b0, '0);
		rd(OFF_PACKET, 32'hC3, RESP_OKAY);
		wait_rx(1);
		chk("rx_pkt", 32'hC3, {24'h0, rx_pkt});
		rd(OFF_PACKET, 32'h0, RESP_OKAY);
	endtask
	task automatic t_window;
		wr(OFF_EVT_EN, 32'h0);
		wr(OFF_WBASE, 32'h0FFFFFFC);
		wr(OFF_WMASK, 32'h00000001);
		ce <= 1'b0;
		ev(1'b1, 1'b0, 1'b0, '0);
		ce <= 1'b1;
		ev(1'b0, 1'b0, 1'b0, '0);
		rd(OFF_PACKET, 32'h0, RESP_OKAY);
		ev(1'b0, 1'b1, 1'b1, {1'b1, 1'b1, 28'hFFFFFFC});
		ev(1'b0, 1'b0, 1'b0, {1'b1, 1'b0, 28'hFFFFFF8});
		ev(1'b0, 1'b0, 1'b0, '0);
		rd(OFF_PACKET, 32'h0, RESP_OKAY);
		ev(1'b0, 1'b0, 1'b0, {1'b1, 1'b0, 28'hFFFFFFF});
		ev(1'b0, 1'b0, 1'b0, '0);
		rd(OFF_PACKET, 32'h02, RESP_OKAY);
		wait_rx(2);
		chk("rx_pkt", 32'h02, {24'h0, rx_pkt});
		repeat (3 * IV) @(posedge aclk);
		chk("rx_cnt", 32'h2, rx_cnt);
		rd(OFF_STATUS, 32'h2, RESP_OKAY);
	endtask
	task automatic summarize;
		if (errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		errors = 0;
		samples_checked = 0;
		aresetn = 1'b0;
		ce = 1'b1;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{vertical_interrupt_flag, instruction_fetch_event, graphics_access_event} = '0;
		cpu_cycle = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_regs();
		t_events();
		t_window();
		summarize();
	end
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		summarize();
	end
endmodule
bind pmevt_top pmevt_top_monitor #(.INTERVAL_CYCLES(INTERVAL_CYCLES)) u_pmevt_top_monitor (
	.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.ser_frame, .ser_data, .ser_done
);
`default_nettype wire
